//--- logic/pin_sync_filter.sv
// Purpose: Two-flop synchroniser plus stable-level filter for one pin
// Assumes: Single clock ref_clk
// Notes: First flop feeds only the second
module pin_sync_filter #(
   parameter int LEN = 3,
   parameter logic INIT = 1'b1
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic pin,
   output logic level,
   output logic rise,
   output logic fall
);
   typedef struct packed {
      logic s1;
      logic s2;
      logic [LEN-1:0] hist;
      logic lvl;
      logic r;
      logic f;
   } state_t;
   state_t q, d;

   always_comb begin
      d = q;
      d.s1 = pin;
      d.s2 = q.s1;
      d.hist = {q.hist[LEN-2:0], q.s2};
      d.r = 1'b0;
      d.f = 1'b0;
      if (&q.hist && !q.lvl) begin
         d.lvl = 1'b1;
         d.r = 1'b1;
      end else if (!(|q.hist) && q.lvl) begin
         d.lvl = 1'b0;
         d.f = 1'b1;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         q <= '{s1: INIT, s2: INIT, hist: {LEN{INIT}}, lvl: INIT,
                r: 1'b0, f: 1'b0};
      end else begin
         q <= d;
      end
   end

   assign level = q.lvl;
   assign rise = q.r;
   assign fall = q.f;
endmodule

//--- logic/psu_mgmt.sv
// Purpose: Slot address decode, I2C readout slave and rail control
// Assumes: Pins synchronous to ref_clk after filtering
// Notes: Readouts arrive as a flat vector of bytes
// Notes on behaviour
// - The slave address is binary 10 followed by the five-bit slot number.
// - The fixed global address 7'h55 is also answered, read or write.
// - Inhibit low turns the main rails off.
// - Main and twelve-volt aux rails are on only for inhibit high, enable low.
// - The 3.3 V aux rail follows enable low, regardless of inhibit.
// - The failure flag is released normally and pulled low on a failure.
// - Active-low slot pins form a binary number, bit one above bit zero.
// - Voltage and temperature readouts are served over I2C.
// - Switching locks to the external reference when present.
// - Outputs-good is held low until all rails are in range.
// - Reads use address-write, memory address, repeated start, read.
module psu_mgmt #(
   parameter int NREG = psu_mgmt_pkg::READOUT_COUNT
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [psu_mgmt_pkg::SLOT_BITS-1:0] geo_slot_n,
   input wire logic geo_slot_parity_n,
   input wire logic inhibit_n,
   input wire logic enable_n,
   input wire logic module_fault,
   input wire logic rails_in_range,
   input wire logic [NREG*8-1:0] readout_bytes,
   input wire logic ext_ref_p,
   input wire logic ext_ref_n,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   output logic main_rails_on,
   output logic aux12_rails_on,
   output logic aux3v3_rail_on,
   output logic fail_out,
   output logic fail_oe,
   output logic outputs_good_out,
   output logic outputs_good_oe,
   output logic switch_pulse,
   output logic ref_locked,
   output logic [6:0] own_addr,
   output logic [7:0] mem_addr
);
   typedef enum logic [2:0] {
      IDLE, ADDR, ADDR_ACK, RX, RX_ACK, TX, TX_ACK
   } i2c_state_t;

   typedef struct packed {
      i2c_state_t st;
      logic [7:0] sh;
      logic [3:0] bits;
      logic rd;
      logic have_ptr;
      logic [7:0] ptr;
      logic sda_oe;
      logic main_on;
      logic aux12_on;
      logic aux33_on;
      logic fail_oe;
      logic good_oe;
      logic [6:0] addr;
      logic sw;
      logic lk;
   } state_t;
   state_t q, d;

   logic scl_lvl, scl_rise, scl_fall;
   logic sda_lvl, sda_rise, sda_fall;
   logic start_cond, stop_cond;
   logic [6:0] slot_addr;
   logic [7:0] rd_byte;
   logic sw_p, lk_w;

   // ----------------------------------------
   // Input conditioning
   // ----------------------------------------
   pin_sync_filter #(.LEN(psu_mgmt_pkg::SYNC_FILT_LEN), .INIT(1'b1)) u_scl (
      .ref_clk(ref_clk),
      .rst(rst),
      .pin(scl_in),
      .level(scl_lvl),
      .rise(scl_rise),
      .fall(scl_fall)
   );
   pin_sync_filter #(.LEN(psu_mgmt_pkg::SYNC_FILT_LEN), .INIT(1'b1)) u_sda (
      .ref_clk(ref_clk),
      .rst(rst),
      .pin(sda_in),
      .level(sda_lvl),
      .rise(sda_rise),
      .fall(sda_fall)
   );
   ref_clk_lock u_lock (
      .ref_clk(ref_clk),
      .rst(rst),
      .ext_ref_p(ext_ref_p),
      .ext_ref_n(ext_ref_n),
      .switch_pulse(sw_p),
      .locked(lk_w)
   );

   assign start_cond = sda_fall && scl_lvl;
   assign stop_cond = sda_rise && scl_lvl;

   // ----------------------------------------
   // Address and readout select
   // ----------------------------------------
   always_comb begin
      // Pins low mean one; bit 0 pin is the LSB
      slot_addr = psu_mgmt_pkg::SLOT_ADDR_BASE
                  | {2'h0, ~geo_slot_n};
      rd_byte = 8'h00;
      if (q.ptr < 8'(NREG)) begin
         rd_byte = readout_bytes[q.ptr*8 +: 8];
      end
   end

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      d = q;
      d.addr = slot_addr;
      d.sw = sw_p;
      d.lk = lk_w;
      d.aux33_on = !enable_n;
      d.main_on = inhibit_n && !enable_n;
      d.aux12_on = inhibit_n && !enable_n;
      d.fail_oe = module_fault;
      d.good_oe = !rails_in_range;
      if (start_cond) begin
         d.st = ADDR;
         d.bits = '0;
         d.sda_oe = 1'b0;
      end else if (stop_cond) begin
         d.st = IDLE;
         d.sda_oe = 1'b0;
      end else begin
         unique case (q.st)
            IDLE: begin
               d.sda_oe = 1'b0;
            end
            ADDR, RX: begin
               if (scl_rise) begin
                  d.sh = {q.sh[6:0], sda_lvl};
                  d.bits = q.bits + 4'h1;
               end
               if (scl_fall && q.bits == 4'h8) begin
                  d.bits = '0;
                  if (q.st == RX) begin
                     d.st = RX_ACK;
                     d.sda_oe = 1'b1;
                     d.ptr = q.sh;
                     d.have_ptr = 1'b1;
                  end else if (q.sh[7:1] == q.addr
                      || q.sh[7:1] == psu_mgmt_pkg::GLOBAL_ADDR) begin
                     d.st = ADDR_ACK;
                     d.sda_oe = 1'b1;
                     d.rd = q.sh[0];
                  end else begin
                     d.st = IDLE;
                  end
               end
            end
            ADDR_ACK, RX_ACK: begin
               if (scl_fall) begin
                  d.sda_oe = 1'b0;
                  if (q.st == ADDR_ACK && q.rd) begin
                     d.st = TX;
                     d.sh = rd_byte;
                     d.sda_oe = !rd_byte[7];
                     d.bits = 4'h1;
                  end else begin
                     d.st = RX;
                  end
               end
            end
            TX: begin
               if (scl_fall) begin
                  if (q.bits == 4'h8) begin
                     d.st = TX_ACK;
                     d.sda_oe = 1'b0;
                     d.bits = '0;
                     d.ptr = q.ptr + 8'h1;
                  end else begin
                     d.sh = {q.sh[6:0], 1'b0};
                     d.sda_oe = !q.sh[6];
                     d.bits = q.bits + 4'h1;
                  end
               end
            end
            TX_ACK: begin
               if (scl_rise) begin
                  d.rd = !sda_lvl;
               end
               if (scl_fall) begin
                  if (q.rd) begin
                     d.st = TX;
                     d.sh = rd_byte;
                     d.sda_oe = !rd_byte[7];
                     d.bits = 4'h1;
                  end else begin
                     d.st = IDLE;
                  end
               end
            end
            default: begin
               d.st = IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         q <= '{st: IDLE, sh: 8'h00, bits: 4'h0, rd: 1'b0,
                have_ptr: 1'b0, ptr: 8'h00, sda_oe: 1'b0,
                main_on: 1'b0, aux12_on: 1'b0, aux33_on: 1'b0,
                fail_oe: 1'b0, good_oe: 1'b1, addr: 7'h00,
                sw: 1'b0, lk: 1'b0};
      end else begin
         q <= d;
      end
   end

   assign sda_out = 1'b0;
   assign sda_oe = q.sda_oe;
   assign main_rails_on = q.main_on;
   assign aux12_rails_on = q.aux12_on;
   assign aux3v3_rail_on = q.aux33_on;
   assign fail_out = 1'b0;
   assign fail_oe = q.fail_oe;
   assign outputs_good_out = 1'b0;
   assign outputs_good_oe = q.good_oe;
   assign switch_pulse = q.sw;
   assign ref_locked = q.lk;
   assign own_addr = q.addr;
   assign mem_addr = q.ptr;
endmodule

//--- logic/ref_clk_lock.sv
// Purpose: Switching-phase pulse generator locked to an external reference
// Assumes: Reference slower than ref_clk / 4
// Notes: Free-runs from a divider when no reference edges arrive
module ref_clk_lock (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic ext_ref_p,
   input wire logic ext_ref_n,
   output logic switch_pulse,
   output logic locked
);
   typedef struct packed {
      logic s1;
      logic s2;
      logic prev;
      logic [15:0] timeout;
      logic [7:0] div;
      logic [2:0] good;
      logic lk;
      logic pulse;
   } state_t;
   state_t q, d;
   logic edge_seen;

   always_comb begin
      d = q;
      d.s1 = ext_ref_p & ~ext_ref_n;
      d.s2 = q.s1;
      d.prev = q.s2;
      edge_seen = q.s2 && !q.prev;
      d.pulse = 1'b0;
      if (edge_seen) begin
         d.timeout = '0;
         if (q.good != 3'(psu_mgmt_pkg::LOCK_GOOD_EDGES)) begin
            d.good = q.good + 3'h1;
         end else begin
            d.lk = 1'b1;
         end
      end else if (q.timeout == 16'(psu_mgmt_pkg::LOCK_TIMEOUT_CYC)) begin
         d.good = '0;
         d.lk = 1'b0;
      end else begin
         d.timeout = q.timeout + 16'h1;
      end
      if (q.lk) begin
         d.pulse = edge_seen;
         d.div = '0;
      end else if (q.div == 8'(psu_mgmt_pkg::FREE_DIV - 1)) begin
         d.div = '0;
         d.pulse = 1'b1;
      end else begin
         d.div = q.div + 8'h1;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign switch_pulse = q.pulse;
   assign locked = q.lk;
endmodule

//--- pkg/psu_mgmt_pkg.sv
// Purpose: Shared constants of the power module management logic
// Assumes: 20 MHz ref_clk
// Notes: Addresses are 7-bit I2C slave addresses
package psu_mgmt_pkg;
   // ----------------------------------------
   // Addressing
   // ----------------------------------------
   localparam logic [6:0] GLOBAL_ADDR = 7'h55;
   localparam logic [6:0] SLOT_ADDR_BASE = 7'h40;
   localparam int SLOT_BITS = 5;
   localparam int MEM_ADDR_W = 8;
   localparam int READOUT_COUNT = 16;
   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CLK_HZ = 20000000;
   localparam int SYNC_FILT_LEN = 3;
   localparam int LOCK_GOOD_EDGES = 4;
   localparam int LOCK_TIMEOUT_NS = 16000;
   localparam int LOCK_TIMEOUT_CYC = LOCK_TIMEOUT_NS / 50;
   localparam int FREE_DIV = 80;
endpackage

//--- tb/i2c_master_model.sv
// Purpose: I2C master on the management bus
// Assumes: SDA pulled up, SCL driven by master only
// Notes: SCL low 20 cycles, high 12 cycles
module i2c_master_model (
   input wire logic ref_clk,
   input wire logic sda_oe,
   output logic scl,
   output logic sda
);
   timeunit 1ns;
   timeprecision 1ps;
   // ----
   // Bus
   // ----
   logic scl_m = 1'b1;
   logic sda_m = 1'b1;
   assign scl = scl_m;
   assign sda = sda_m & ~sda_oe;
   task automatic wt(input int n);
      repeat (n) @(negedge ref_clk);
   endtask
   task automatic start();
      sda_m = 1'b1;
      wt(10);
      scl_m = 1'b1;
      wt(12);
      sda_m = 1'b0;
      wt(12);
      scl_m = 1'b0;
      wt(10);
   endtask
   task automatic stop();
      sda_m = 1'b0;
      wt(10);
      scl_m = 1'b1;
      wt(12);
      sda_m = 1'b1;
      wt(12);
   endtask
   task automatic bitx(input logic b, output logic s);
      sda_m = b;
      wt(10);
      scl_m = 1'b1;
      wt(6);
      s = sda;
      wt(6);
      scl_m = 1'b0;
      wt(10);
   endtask
   task automatic write_byte(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bitx(b[i], s);
      end
      bitx(1'b1, s);
      ack = ~s;
   endtask
   task automatic read_byte(input logic last, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bitx(1'b1, d[i]);
      end
      bitx(last, s);
   endtask
endmodule

//--- tb/psu_mgmt_properties.sv
// Purpose: Port checks of psu_mgmt
// Assumes: Bound to every psu_mgmt
// Notes: Fail and outputs-good levels get three cycles to settle, rails one or two
module psu_mgmt_checker (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [psu_mgmt_pkg::SLOT_BITS-1:0] geo_slot_n,
   input wire logic inhibit_n,
   input wire logic enable_n,
   input wire logic module_fault,
   input wire logic rails_in_range,
   input wire logic scl_in,
   input wire logic sda_oe,
   input wire logic main_rails_on,
   input wire logic aux12_rails_on,
   input wire logic aux3v3_rail_on,
   input wire logic fail_oe,
   input wire logic outputs_good_oe,
   input wire logic switch_pulse,
   input wire logic ref_locked,
   input wire logic [6:0] own_addr
);
   timeunit 1ns;
   timeprecision 1ps;
   // ----
   // Properties
   // ----
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   property p_inhibit;
      !inhibit_n |=> !main_rails_on && !aux12_rails_on;
   endproperty
   a_inhibit: assert property (p_inhibit) else $error("inhibit");
   property p_main_on;
      (inhibit_n && !enable_n)[*2] |-> main_rails_on && aux12_rails_on;
   endproperty
   a_main_on: assert property (p_main_on) else $error("main on");
   property p_main_off;
      enable_n |=> !main_rails_on && !aux12_rails_on;
   endproperty
   a_main_off: assert property (p_main_off) else $error("main off");
   property p_aux3;
      !$past(rst) |-> aux3v3_rail_on == !$past(enable_n);
   endproperty
   a_aux3: assert property (p_aux3) else $error("aux3v3");
   property p_fail_on;
      module_fault[*3] |-> fail_oe;
   endproperty
   a_fail_on: assert property (p_fail_on) else $error("fail on");
   property p_fail_off;
      !module_fault[*3] |-> !fail_oe;
   endproperty
   a_fail_off: assert property (p_fail_off) else $error("fail off");
   property p_good_hold;
      !rails_in_range[*3] |-> outputs_good_oe;
   endproperty
   a_good_hold: assert property (p_good_hold) else $error("og");
   property p_good_free;
      rails_in_range[*3] |-> !outputs_good_oe;
   endproperty
   a_good_free: assert property (p_good_free) else $error("og");
   property p_addr;
      $stable(geo_slot_n)[*8] |-> own_addr == {2'h2, ~geo_slot_n};
   endproperty
   a_addr: assert property (p_addr) else $error("addr");
   property p_pulse;
      switch_pulse |=> !switch_pulse;
   endproperty
   a_pulse: assert property (p_pulse) else $error("pulse");
   property p_sda;
      $changed(sda_oe) |-> !scl_in;
   endproperty
   a_sda: assert property (p_sda) else $error("sda");
   c_ack: cover property ($rose(sda_oe));
   c_lock: cover property ($rose(ref_locked));
   c_main: cover property (main_rails_on);
endmodule

bind psu_mgmt psu_mgmt_checker psu_mgmt_checker_i (.ref_clk, .rst,
   .geo_slot_n, .inhibit_n, .enable_n, .module_fault, .rails_in_range,
   .scl_in, .sda_oe, .main_rails_on, .aux12_rails_on, .aux3v3_rail_on,
   .fail_oe, .outputs_good_oe, .switch_pulse, .ref_locked, .own_addr);

//--- tb/tb_psu_mgmt.sv
// Purpose: Self-checking bench of psu_mgmt
// Assumes: I2C master model on the bus
// Notes: Rows hold rail and flag levels
module tb_psu_mgmt;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk, rst, inhibit_n, enable_n, module_fault, rails_in_range;
   logic ext_ref_p, ext_ref_n, scl, sda, sda_out, sda_oe, main_rails_on;
   logic aux12_rails_on, aux3v3_rail_on, fail_out, fail_oe, switch_pulse;
   logic outputs_good_out, outputs_good_oe, ref_locked, ack;
   logic [psu_mgmt_pkg::SLOT_BITS-1:0] geo_slot_n;
   logic [4:0] slots [2] = '{5'h01, 5'h10};
   logic [6:0] own_addr;
   logic [7:0] mem_addr, d0, d1, v;
   logic [127:0] readout_bytes;
   logic [8:0] rows [4] = '{9'h005, 9'h066, 9'h13c, 9'h1c3};
   int fails = 0;
   int n_tests = 0;
   psu_mgmt psu_mgmt_i (.ref_clk, .rst, .geo_slot_n,
      .geo_slot_parity_n(1'b1), .inhibit_n, .enable_n, .module_fault,
      .rails_in_range, .readout_bytes, .ext_ref_p, .ext_ref_n,
      .scl_in(scl), .sda_in(sda), .sda_out, .sda_oe, .main_rails_on,
      .aux12_rails_on, .aux3v3_rail_on, .fail_out, .fail_oe,
      .outputs_good_out, .outputs_good_oe, .switch_pulse, .ref_locked,
      .own_addr, .mem_addr);
   i2c_master_model i2c_master_model_i (.ref_clk, .sda_oe, .scl, .sda);
   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end
   // ----
   // Tasks
   // ----
   task automatic check(input string what, input logic [7:0] exp, got);
      n_tests++;
      if (got !== exp) begin
         fails++;
         $display("BAD %s exp %h got %h", what, exp, got);
      end
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge ref_clk);
   endtask
   task automatic send(input logic [7:0] b, input logic exp);
      i2c_master_model_i.write_byte(b, ack);
      check("ack", {7'h0, exp}, {7'h0, ack});
   endtask
   task automatic read_pair(input logic [6:0] a, input logic [7:0] p,
      e0, e1);
      i2c_master_model_i.start();
      send({a, 1'b0}, 1'b1);
      send(p, 1'b1);
      i2c_master_model_i.start();
      send({a, 1'b1}, 1'b1);
      i2c_master_model_i.read_byte(1'b0, d0);
      i2c_master_model_i.read_byte(1'b1, d1);
      i2c_master_model_i.stop();
      check("rd0", e0, d0);
      check("rd1", e1, d1);
      check("ptr", p + 8'h02, mem_addr);
   endtask
   // ----
   // Sequence
   // ----
   initial begin
      rst = 1'b1;
      {inhibit_n, enable_n, module_fault, rails_in_range} = 4'h8;
      ext_ref_p = 1'b0;
      ext_ref_n = 1'b1;
      geo_slot_n = ~5'h10;
      for (int k = 0; k < 16; k++) begin
         readout_bytes[k*8+:8] = 8'h30 + 8'(k);
      end
      cyc(8);
      check("og_rst", 8'h01, {7'h0, outputs_good_oe});
      cyc(8);
      rst = 1'b0;
      $display("test reset done");
      foreach (rows[i]) begin
         {inhibit_n, enable_n, module_fault, rails_in_range} = rows[i][8:5];
         cyc(6);
         v = {3'h0, main_rails_on, aux12_rails_on, aux3v3_rail_on, fail_oe,
            outputs_good_oe};
         check("rails", {3'h0, rows[i][4:0]}, v);
      end
      $display("test rows done");
      foreach (slots[i]) begin
         geo_slot_n = ~slots[i];
         cyc(10);
         check("addr", {3'h2, slots[i]}, {1'b0, own_addr});
      end
      i2c_master_model_i.start();
      send({7'h41, 1'b0}, 1'b0);
      i2c_master_model_i.stop();
      read_pair(7'h50, 8'h0f, 8'h3f, 8'h00);
      read_pair(7'h55, 8'h0e, 8'h3e, 8'h3f);
      $display("test i2c done");
      for (int i = 0; i < 200 && ref_locked !== 1'b1; i++) begin
         cyc(20);
         ext_ref_p = ~ext_ref_p;
         ext_ref_n = ~ext_ref_p;
      end
      check("lock", 8'h01, {7'h0, ref_locked});
      cyc(400);
      check("unlock", 8'h00, {7'h0, ref_locked});
      v = 8'h00;
      for (int i = 0; i < 160; i++) begin
         cyc(1);
         v = v + {7'h0, switch_pulse};
      end
      check("pulses", 8'h02, v);
      $display("test lock done");
      finish_test();
   end
endmodule
